// [hw/dfg_top.sv]
// Purpose: flag outputs and general-purpose pins for subsystems a and b
// Assumes: classic wishbone slave, single synchronous clock
// Notes: unmapped reads return zero and are acked
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module dfg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // chip level controls
  input wire logic output_disable_n_i,   // low floats flag pins
  input wire logic port_mode_select_i,   // 0 host port, 1 memory interface
  input wire logic timer_a_i,
  input wire logic timer_b_i,
  input wire logic io_strobe_n_i,
  input wire logic io_sel_n_i,
  // flag pins
  output logic sub_a_flag_out_o,
  output logic sub_a_flag_oe_o,
  output logic sub_b_flag_out_o,
  output logic sub_b_flag_oe_o,
  // pins
  input wire logic [3:0] sub_a_pin_i,
  output logic [3:0] sub_a_pin_o,
  output logic [3:0] sub_a_pin_oe_o,
  input wire logic [3:0] sub_b_pin_i,
  output logic [3:0] sub_b_pin_o,
  output logic [3:0] sub_b_pin_oe_o,
  output logic sub_a_branch_o,
  output logic sub_b_branch_o,
  output logic sub_a_rom_enable_strap_o,
  output logic sub_b_rom_enable_strap_o
);
  logic [1:0] flag_reg;      // latched flag bits
  logic ack_reg;             // single ack pulse
  logic [31:0] rd_reg;       // read data
  logic [1:0] strap_reg;     // rom enable straps
  logic strap_taken_reg;     // strap captured once after reset
  logic [31:0] a_rdat;
  logic [31:0] b_rdat;

  ////////////////////////////////////////////////////////////////
  // bus decode; full word writes only need sel, partial writes still taken
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr = req && wb_we_i && (wb_sel_i != 4'h0);
  wire hit_flag = wb_adr_i == dfg_pkg::DFG_OFF_FLAG;
  wire hit_a = wb_adr_i == dfg_pkg::DFG_OFF_A_PIN;
  wire hit_b = wb_adr_i == dfg_pkg::DFG_OFF_B_PIN;
  wire hit_stat = wb_adr_i == dfg_pkg::DFG_OFF_STAT;
  // per-bit set/clear strobes give bit addressing without read-modify-write
  wire [1:0] fset = wb_dat_i[dfg_pkg::DFG_FSET_LSB +: 2];
  wire [1:0] fclr = wb_dat_i[dfg_pkg::DFG_FCLR_LSB +: 2];
  wire [1:0] fplain = wb_dat_i[1:0];
  wire fstrobe = (fset | fclr) != 2'b00;
  wire [1:0] flag_next = fstrobe ? ((flag_reg & ~fclr) | fset) : fplain;
  wire [31:0] stat_word = {29'h0, port_mode_select_i, strap_reg};
  wire [31:0] rd_next = hit_flag ? {30'h0, flag_reg} :
                        hit_a ? a_rdat :
                        hit_b ? b_rdat :
                        hit_stat ? stat_word : 32'h0;

  // flag latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= {2{dfg_pkg::DFG_RST_FLAG}};
    end else if (wr && hit_flag) begin
      flag_reg <= flag_next;
    end
  end

  // wishbone ack and read data, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= req;
      rd_reg <= req ? rd_next : rd_reg;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;

  ////////////////////////////////////////////////////////////////
  // flag pads: output disable floats both
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_a_flag_out_o <= 1'b0;
      sub_b_flag_out_o <= 1'b0;
      sub_a_flag_oe_o <= 1'b0;
      sub_b_flag_oe_o <= 1'b0;
    end else begin
      sub_a_flag_out_o <= flag_reg[0];
      sub_b_flag_out_o <= flag_reg[1];
      sub_a_flag_oe_o <= output_disable_n_i;
      sub_b_flag_oe_o <= output_disable_n_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // rom enable strap: pin 0 captured at first edge after reset in xio mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_reg <= 2'b00;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= port_mode_select_i ? {sub_b_pin_i[0], sub_a_pin_i[0]} : 2'b00;
    end
  end
  assign sub_a_rom_enable_strap_o = strap_reg[0];
  assign sub_b_rom_enable_strap_o = strap_reg[1];

  ////////////////////////////////////////////////////////////////
  // the two subsystems; mode pin level held by board
  dfg_sub_pins u_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr && hit_a),
    .wdat_i(wb_dat_i),
    .port_mode_select_i(port_mode_select_i),
    .timer_in_i(timer_a_i),
    .io_strobe_n_i(io_strobe_n_i),
    .io_sel_n_i(1'b0),
    .pin_i(sub_a_pin_i),
    .pin_o(sub_a_pin_o),
    .pin_oe_o(sub_a_pin_oe_o),
    .rdat_o(a_rdat),
    .branch_condition_input_o(sub_a_branch_o)
  );
  dfg_sub_pins u_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr && hit_b),
    .wdat_i(wb_dat_i),
    .port_mode_select_i(port_mode_select_i),
    .timer_in_i(timer_b_i),
    .io_strobe_n_i(1'b0),
    .io_sel_n_i(io_sel_n_i),
    .pin_i(sub_b_pin_i),
    .pin_o(sub_b_pin_o),
    .pin_oe_o(sub_b_pin_oe_o),
    .rdat_o(b_rdat),
    .branch_condition_input_o(sub_b_branch_o)
  );

  a_flag_float: assert property (@(posedge clk_i) disable iff (rst_i)
    !output_disable_n_i |=> !sub_a_flag_oe_o && !sub_b_flag_oe_o)
    else $error("flag pin driven while outputs disabled");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && hit_flag && wb_dat_i[dfg_pkg::DFG_FSET_LSB] && !wb_dat_i[dfg_pkg::DFG_FCLR_LSB]
    |=> ##1 sub_a_flag_out_o)
    else $error("flag set strobe not seen on pin");
  // strap is taken once per reset and must not drift afterwards
  a_strap_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    strap_taken_reg |=> $stable(strap_reg))
    else $error("rom enable strap changed after capture");
endmodule : dfg_top

// [inc/dfg_pkg.sv]
// Purpose: constants for the dual subsystem flag and general-purpose pin block
// Assumes: classic wishbone register access, one 250 MHz clock
// Notes: register offsets and pin/flag field positions live here; status word bits are laid out only in dfg_top
package dfg_pkg;
  // register byte offsets
  localparam logic [3:0] DFG_OFF_FLAG = 4'h0;   // flag bits, bit0 sub a, bit1 sub b
  localparam logic [3:0] DFG_OFF_A_PIN = 4'h4;  // sub a pin register
  localparam logic [3:0] DFG_OFF_B_PIN = 4'h8;  // sub b pin register
  localparam logic [3:0] DFG_OFF_STAT = 4'hc;   // strap and mode status, read only
  // pin register fields
  localparam int DFG_DATA_LSB = 0;   // pin data bits 3:0
  localparam int DFG_DIR_LSB = 8;    // direction bits 11:8, 1 = output
  localparam int DFG_TIMER_OUT_SELECT_BIT = 12;  // timer output select for pin 3
  localparam int DFG_MUX_BIT = 13;   // host mux mode bit, 1 = multiplexed (pin 3 not general purpose)
  // flag register fields: bits 1:0 values, bits 9:8 set strobes, 17:16 clear strobes
  localparam int DFG_FSET_LSB = 8;
  localparam int DFG_FCLR_LSB = 16;
  // reset values
  localparam logic [3:0] DFG_RST_DIR = 4'h0;
  localparam logic [3:0] DFG_RST_DATA = 4'h0;
  localparam logic DFG_RST_TIMER_OUT_SELECT = 1'b0;
  localparam logic DFG_RST_MUX = 1'b0;
  localparam logic DFG_RST_FLAG = 1'b0;
  localparam int DFG_NPINS = 4;
endpackage : dfg_pkg

// [hw/dfg_sub_pins.sv]
// Purpose: one subsystem's four pins with direction, latch and pin 3 mux
// Assumes: pin inputs synchronous to clk_i
// Notes: pin 3 source chosen from port mode, mux mode and timer select
`timescale 1ns/1ps
module dfg_sub_pins #(
  parameter int NPINS = dfg_pkg::DFG_NPINS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,                 // pin register write strobe
  input wire logic [31:0] wdat_i,        // write data
  input wire logic port_mode_select_i,   // 1 = memory interface mode
  input wire logic timer_in_i,           // timer output from core
  input wire logic io_strobe_n_i,        // io space strobe, active low
  input wire logic io_sel_n_i,           // io space select, active low
  input wire logic [NPINS-1:0] pin_i,    // pad levels
  output logic [NPINS-1:0] pin_o,        // pad drive values
  output logic [NPINS-1:0] pin_oe_o,     // pad enables
  output logic [31:0] rdat_o,            // register read view
  output logic branch_condition_input_o  // branch condition level
);
  initial begin
    if (NPINS != 4) $error("dfg_sub_pins serves exactly four pins");
  end
  logic [3:0] data_reg;   // latched output values
  logic [3:0] dir_reg;    // 1 = output
  logic timer_out_select_reg;         // timer select
  logic mux_reg;          // host mux mode
  logic [3:0] in_reg;     // sampled pad levels

  ////////////////////////////////////////////////////////////////
  // register latch; reset leaves all pins as inputs, except pin 3 driven in memory mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_reg <= dfg_pkg::DFG_RST_DATA;
      dir_reg <= dfg_pkg::DFG_RST_DIR;
      timer_out_select_reg <= dfg_pkg::DFG_RST_TIMER_OUT_SELECT;
      mux_reg <= dfg_pkg::DFG_RST_MUX;
    end else if (wr_i) begin
      data_reg <= wdat_i[dfg_pkg::DFG_DATA_LSB +: 4];
      dir_reg <= wdat_i[dfg_pkg::DFG_DIR_LSB +: 4];
      timer_out_select_reg <= wdat_i[dfg_pkg::DFG_TIMER_OUT_SELECT_BIT];
      mux_reg <= wdat_i[dfg_pkg::DFG_MUX_BIT];
    end
  end

  // pad sampling, one flop so reads see settled levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reg <= 4'h0;
    end else begin
      in_reg <= pin_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin 3 ownership
  wire mem_mode = port_mode_select_i;
  wire gpio3_own = !mem_mode && !mux_reg;
  wire timer_out_select_on = gpio3_own && timer_out_select_reg;
  // strobe and select share the pad: asserted only for io space cycles
  wire io_active = !io_strobe_n_i && !io_sel_n_i;
  wire [3:0] drv_val = {mem_mode ? !io_active : (timer_out_select_on ? timer_in_i : data_reg[3]),
                        data_reg[2:0]};
  wire [3:0] drv_en = {mem_mode | timer_out_select_on | (gpio3_own & dir_reg[3]), dir_reg[2:0]};
  // read view: input pins show pad level, outputs show latch
  wire [3:0] rd_pins = (in_reg & ~dir_reg) | (data_reg & dir_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 4'h0;
      pin_oe_o <= 4'h0;
      rdat_o <= 32'h0;
      branch_condition_input_o <= 1'b0;
    end else begin
      pin_o <= drv_val;
      pin_oe_o <= drv_en;
      rdat_o <= {18'h0, mux_reg, timer_out_select_reg, dir_reg, 4'h0, rd_pins};
      branch_condition_input_o <= !dir_reg[2] && in_reg[2];
    end
  end

  a_dir_drives: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(wr_i) && !$past(rst_i,2) |-> ##1 pin_oe_o[1:0] == dir_reg[1:0])
    else $error("pin enable does not follow direction");
  a_mem_pin3: assert property (@(posedge clk_i) disable iff (rst_i)
    port_mode_select_i |=> pin_oe_o[3])
    else $error("pin 3 not driven in memory mode");
endmodule : dfg_sub_pins

// [sim/dfg_board.sv]
// Purpose: board logic on the far side of both pin groups
// Assumes: board drives every pad that the device leaves undriven
// Notes: mode pin is a board strap, held steady by the board
`timescale 1ns/1ps
module dfg_board (
  input wire logic [3:0] a_o_i,
  input wire logic [3:0] a_oe_i,
  input wire logic [3:0] b_o_i,
  input wire logic [3:0] b_oe_i,
  input wire logic [3:0] a_drv_i,
  input wire logic [3:0] b_drv_i,
  input wire logic mode_req_i,
  output logic [3:0] a_lvl_o,
  output logic [3:0] b_lvl_o,
  output logic mode_o
);
  // pad level: device wins while enabled, board elsewhere (pin 0 strap too)
  assign a_lvl_o = (a_oe_i & a_o_i) | (~a_oe_i & a_drv_i);
  assign b_lvl_o = (b_oe_i & b_o_i) | (~b_oe_i & b_drv_i);
  // low picks host port, high memory interface
  assign mode_o = mode_req_i;
endmodule : dfg_board

// [sim/tb_top.sv]
// Purpose: self-checking bench for the flag and pin block
// Assumes: one 250 MHz clock, classic wishbone single cycles
// Notes: outputs are judged three cycles after each bus access
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, adrv = 4'h0, bdrv = 4'h0, al, bl, aoe, boe, ao, bo;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic odis_n = 1'b1, mode_req = 1'b0, mode, ta = 1'b0, tb = 1'b0;
  logic ios_n = 1'b1, isel_n = 1'b1, afo, afe, bfo, bfe, abr, bbr, ast, bst, ack;
  int fail_count = 0, total_checks = 0;
  initial forever #2 clk_i = ~clk_i;
  dfg_board dfg_board_inst (.a_o_i(ao), .a_oe_i(aoe), .b_o_i(bo), .b_oe_i(boe),
    .a_drv_i(adrv), .b_drv_i(bdrv), .mode_req_i(mode_req), .a_lvl_o(al),
    .b_lvl_o(bl), .mode_o(mode));
  dfg_top dfg_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .output_disable_n_i(odis_n), .port_mode_select_i(mode),
    .timer_a_i(ta), .timer_b_i(tb), .io_strobe_n_i(ios_n), .io_sel_n_i(isel_n),
    .sub_a_flag_out_o(afo), .sub_a_flag_oe_o(afe), .sub_b_flag_out_o(bfo),
    .sub_b_flag_oe_o(bfe), .sub_a_pin_i(al), .sub_a_pin_o(ao), .sub_a_pin_oe_o(aoe),
    .sub_b_pin_i(bl), .sub_b_pin_o(bo), .sub_b_pin_oe_o(boe), .sub_a_branch_o(abr),
    .sub_b_branch_o(bbr), .sub_a_rom_enable_strap_o(ast), .sub_b_rom_enable_strap_o(bst));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 50) begin
      chk(32'h1, 32'h0);
      final_report;
    end
  endtask : wb
  // let registered outputs land
  task sett;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : sett
  task do_reset;
    @(posedge clk_i); rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    sett;
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  // reset defaults, then strap captured in memory mode
  task t_reset;
    chk({aoe, boe}, 8'h00);
    wb(1'b0, dfg_pkg::DFG_OFF_A_PIN, 32'h0); chk(q[13:8], 6'h00);
    wb(1'b0, 4'h2, 32'h0); chk(q, 32'h0);
    mode_req <= 1'b1; adrv <= 4'h1; bdrv <= 4'h0;
    do_reset;
    chk({ast, bst}, 2'b10);
    wb(1'b0, dfg_pkg::DFG_OFF_STAT, 32'h0); chk(q[2:0], 3'h5);
  endtask : t_reset
  // io strobe and select on pin 3 in memory mode
  task t_memmode;
    ios_n <= 1'b0; isel_n <= 1'b1; sett;
    chk({aoe[3], ao[3], boe[3], bo[3]}, 4'b1011);
    ios_n <= 1'b1; isel_n <= 1'b0; sett;
    chk({ao[3], bo[3]}, 2'b10);
    mode_req <= 1'b0; adrv <= 4'h0; do_reset;
  endtask : t_memmode
  // flag set, clear and float
  task t_flag;
    wb(1'b1, dfg_pkg::DFG_OFF_FLAG, 32'h0000_0100); sett;
    chk({afo, afe, bfo, bfe}, 4'b1101);
    wb(1'b1, dfg_pkg::DFG_OFF_FLAG, 32'h0001_0200); sett;
    chk({afo, bfo}, 2'b01);
    wb(1'b0, dfg_pkg::DFG_OFF_FLAG, 32'h0); chk(q[1:0], 2'b10);
    odis_n <= 1'b0; sett;
    chk({afe, bfe}, 2'b00);
    odis_n <= 1'b1;
  endtask : t_flag
  // direction, latch, input read, branch, pin 3 routing
  task t_pins;
    wb(1'b1, dfg_pkg::DFG_OFF_A_PIN, 32'h0000_0b05); sett;
    chk({aoe, ao & 4'hb}, 8'hb1);
    wb(1'b0, dfg_pkg::DFG_OFF_A_PIN, 32'h0); chk(q[11:0], 12'hb01);
    chk(abr, 1'b0);
    adrv <= 4'h4; sett;
    chk(abr, 1'b1);
    wb(1'b0, dfg_pkg::DFG_OFF_A_PIN, 32'h0); chk(q[3:0], 4'h5);
    wb(1'b1, dfg_pkg::DFG_OFF_A_PIN, 32'h0000_1b05); ta <= 1'b1; sett;
    chk({aoe[3], ao[3]}, 2'b11);
    ta <= 1'b0; sett;
    chk(ao[3], 1'b0);
    wb(1'b1, dfg_pkg::DFG_OFF_B_PIN, 32'h0000_2f0f); sett;
    chk(boe, 4'h7);
    wb(1'b1, dfg_pkg::DFG_OFF_B_PIN, 32'h0000_0f0f); sett;
    chk({boe, bo}, 8'hff);
    chk(bbr, 1'b0);
  endtask : t_pins
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    sett;
    t_reset;
    t_memmode;
    t_flag;
    t_pins;
    final_report;
  end
  // watchdog well past the expected run
  initial begin
    #100000;
    fail_count++;
    final_report;
  end
endmodule : tb_top
